//--- hdl/fault_pkg.sv
/*
 * Constants, register map and state encoding of the buck converter fault logic.
 * Assumes a 100 MHz hclk and an AHB-Lite master doing single word transfers.
 */
package fault_pkg;

	// --------------------------------------------------------------
	// timing
	// --------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int HICCUP_TIME_NS = 1_280_000;
	localparam int HICCUP_CYCLES = (HICCUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int MIN_START_TIME_NS = 1_280_000;
	localparam int MIN_START_CYCLES = (MIN_START_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DEGLITCH_TIME_NS = 20_000;
	localparam int DEGLITCH_CYCLES = (DEGLITCH_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TIMER_W = 17;
	localparam int DEGLITCH_W = 12;

	// --------------------------------------------------------------
	// over-current counting
	// --------------------------------------------------------------
	localparam logic [5:0] QUIET_LAST = 6'h1F;
	localparam logic [2:0] OC_TRIP_PREV = 3'h4;

	// --------------------------------------------------------------
	// register map
	// --------------------------------------------------------------
	localparam int ADDR_W = 8;
	localparam logic [7:0] CTRL_OFF = 8'h00;
	localparam logic [7:0] STATUS_OFF = 8'h04;
	localparam logic [7:0] HICCUP_CNT_OFF = 8'h08;
	localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
	localparam int CTRL_EN_BIT = 0;
	localparam int ST_STATE_LSB = 0;
	localparam int ST_COUNT_LSB = 4;
	localparam int ST_OT_BIT = 8;
	localparam int ST_OV_BIT = 9;
	localparam int ST_UV_BIT = 10;
	localparam int ST_LOCKOUT_BIT = 11;
	localparam int ST_REGULATION_OK_FLAG_BIT = 12;
	localparam int ST_HSBLOCK_BIT = 13;
	localparam int ST_NEGBLOCK_BIT = 14;
	localparam logic [1:0] HTRANS_NONSEQ_BIT1 = 2'h2;

	// --------------------------------------------------------------
	// synchronised pin inputs, bit positions
	// --------------------------------------------------------------
	localparam int IN_W = 14;
	localparam int I_OC = 0;
	localparam int I_OV = 1;
	localparam int I_UV = 2;
	localparam int I_LOCK = 3;
	localparam int I_OT = 4;
	localparam int I_SWPOS = 5;
	localparam int I_IZERO = 6;
	localparam int I_CYC = 7;
	localparam int I_EN = 8;
	localparam int I_UNREG = 9;
	localparam int I_SSFB = 10;
	localparam int I_PWMH = 11;
	localparam int I_PWML = 12;
	localparam int I_SSDONE = 13;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_START = 3'b001,
		ST_RUN = 3'b010,
		ST_HIC_DRAIN = 3'b011,
		ST_HIC_WAIT = 3'b100
	} state_e;

endpackage

//--- hdl/sync2.sv
/*
 * Two flip-flop synchroniser for a vector of independent level inputs.
 * Assumes each bit is a slow level; no bus coherency between bits.
 */
`timescale 1ns/1ps
module sync2 #(
	parameter int W = 1
) (
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, active low
	input wire logic [W-1:0] d, // asynchronous levels
	output logic [W-1:0] q // synchronised levels
);
	// --------------------------------------------------------------
	// per bit stages
	// --------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic meta_reg;
			always_ff @(posedge hclk or negedge hresetn)
			begin
				if (!hresetn)
				begin
					meta_reg <= 1'b0;
					q[i] <= 1'b0;
				end
				else
				begin
					meta_reg <= d[i];
					q[i] <= meta_reg;
				end
			end
		end
	endgenerate
endmodule

//--- hdl/deglitch.sv
/*
 * Symmetric deglitch filter: apart from force_low, which drops it at once, the output
 * follows the input only after the input has held its new level for CYCLES consecutive clocks.
 * Assumes raw is already synchronous to hclk.
 */
`timescale 1ns/1ps
module deglitch #(
	parameter int CYCLES = fault_pkg::DEGLITCH_CYCLES
) (
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, active low
	input wire logic raw, // unfiltered level
	input wire logic force_low, // drops output at once
	output logic filt // filtered level
);
	import fault_pkg::*;

	logic [DEGLITCH_W-1:0] cnt_reg;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_reg <= '0;
			filt <= 1'b0;
		end
		else if (force_low)
		begin
			cnt_reg <= '0;
			filt <= 1'b0;
		end
		else if (raw == filt)
		begin
			cnt_reg <= '0;
		end
		else if (cnt_reg == DEGLITCH_W'(CYCLES - 1))
		begin
			cnt_reg <= '0;
			filt <= raw;
		end
		else
		begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end
endmodule

//--- hdl/buck_fault_protection_logic.sv
/*
 * Fault management of a synchronous buck controller: cycle-by-cycle current
 * limit, over-current counter and hiccup sequence, soft-start discharge,
 * negative current limit, deglitched regulation flag, thermal shutdown,
 * and an AHB-Lite register slave.
 * Assumes all comparator and modulator inputs are asynchronous levels and
 * that sw_cycle rises once per switching period.
 */
`timescale 1ns/1ps
module buck_fault_protection_logic #(
	parameter int HICCUP_CYC = fault_pkg::HICCUP_CYCLES, // hiccup off time
	parameter int MIN_START_CYC = fault_pkg::MIN_START_CYCLES // shortest ramp
) (
	input wire logic hclk, // 100 MHz clock
	input wire logic hresetn, // async reset, active low
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // response, always okay
	output logic [31:0] hrdata, // read data
	input wire logic oc_comp, // over-current comparator
	input wire logic ov_comp, // over-voltage comparator
	input wire logic uv_comp, // under-voltage comparator
	input wire logic supply_lockout, // supply below lockout
	input wire logic ot_comp, // over-temperature
	input wire logic switch_node_pos, // switch node above +100mV
	input wire logic izero_comp, // inductor current at zero
	input wire logic sw_cycle, // rises at each switching cycle
	input wire logic enable_pin, // enable comparator
	input wire logic out_unreg, // output unregulated or pre-biased
	input wire logic ss_above_fb, // soft-start above feedback
	input wire logic pwm_hs, // modulator high-side request
	input wire logic pwm_ls, // modulator low-side request
	input wire logic ss_done, // soft-start ramp complete
	output logic hs_en, // high-side gate enable
	output logic ls_en, // low-side gate enable
	output logic ss_pulldown, // soft-start discharge switch
	output logic regulation_ok_flag // power good
);
	import fault_pkg::*;

	// --------------------------------------------------------------
	// input synchronisation
	// --------------------------------------------------------------
	logic [IN_W-1:0] pins_raw;
	logic [IN_W-1:0] pins_s;
	logic cyc_d_reg;
	logic cyc_start;
	logic oc_s;
	logic ov_s;
	logic ot_s;
	logic lock_s;

	assign pins_raw[I_OC] = oc_comp;
	assign pins_raw[I_OV] = ov_comp;
	assign pins_raw[I_UV] = uv_comp;
	assign pins_raw[I_LOCK] = supply_lockout;
	assign pins_raw[I_OT] = ot_comp;
	assign pins_raw[I_SWPOS] = switch_node_pos;
	assign pins_raw[I_IZERO] = izero_comp;
	assign pins_raw[I_CYC] = sw_cycle;
	assign pins_raw[I_EN] = enable_pin;
	assign pins_raw[I_UNREG] = out_unreg;
	assign pins_raw[I_SSFB] = ss_above_fb;
	assign pins_raw[I_PWMH] = pwm_hs;
	assign pins_raw[I_PWML] = pwm_ls;
	assign pins_raw[I_SSDONE] = ss_done;

	sync2 #(
		.W(IN_W)
	) u_sync (
		.hclk(hclk),
		.hresetn(hresetn),
		.d(pins_raw),
		.q(pins_s)
	);

	assign oc_s = pins_s[I_OC];
	assign ov_s = pins_s[I_OV];
	assign ot_s = pins_s[I_OT];
	assign lock_s = pins_s[I_LOCK];

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			cyc_d_reg <= 1'b0;
		else
			cyc_d_reg <= pins_s[I_CYC];
	end

	assign cyc_start = pins_s[I_CYC] & ~cyc_d_reg;

	// --------------------------------------------------------------
	// declarations shared by the sections below
	// --------------------------------------------------------------
	state_e state_reg;
	state_e state_next;
	logic [TIMER_W-1:0] timer_reg;
	logic [31:0] ctrl_reg;
	logic [7:0] hiccup_cnt_reg;
	logic hs_block_reg;
	logic oc_seen_reg;
	logic [2:0] oc_count_reg;
	logic [5:0] quiet_reg;
	logic neg_block_reg;
	logic limiting;
	logic oc_event;
	logic quiet_clear;
	logic trip;
	logic enabled;
	logic shutdown;
	logic switching;
	logic pg_raw;
	logic wr_pend_reg;
	logic [31:0] wr_addr_reg;
	logic addr_valid;
	logic hic_clear;

	assign limiting = (state_reg == ST_START) || (state_reg == ST_RUN);
	assign enabled = pins_s[I_EN] & ctrl_reg[CTRL_EN_BIT];
	assign shutdown = ot_s | lock_s | ~enabled;

	// --------------------------------------------------------------
	// over-current detection and counting
	// --------------------------------------------------------------
	// an event counts once per cycle, the first cycle edge re-arms it
	assign oc_event = limiting & oc_s & (~oc_seen_reg | cyc_start);
	assign quiet_clear = cyc_start & ~oc_seen_reg & (quiet_reg == QUIET_LAST);
	assign trip = oc_event & ~quiet_clear
		& (oc_count_reg == OC_TRIP_PREV);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hs_block_reg <= 1'b0;
		else if (!limiting)
			hs_block_reg <= 1'b0;
		else if (oc_s)
			hs_block_reg <= 1'b1;
		else if (cyc_start)
			hs_block_reg <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			oc_seen_reg <= 1'b0;
		else if (!limiting)
			oc_seen_reg <= 1'b0;
		else if (cyc_start)
			oc_seen_reg <= oc_s;
		else if (oc_s)
			oc_seen_reg <= 1'b1;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			quiet_reg <= '0;
		else if (!limiting)
			quiet_reg <= '0;
		else if (cyc_start)
		begin
			if (oc_seen_reg || quiet_clear)
				quiet_reg <= '0;
			else
				quiet_reg <= quiet_reg + 1'b1;
		end
	end

	// a new event in the clearing cycle still counts as the first
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			oc_count_reg <= '0;
		else if (!limiting || trip)
			oc_count_reg <= '0;
		else if (oc_event)
			oc_count_reg <= quiet_clear ? 3'h1 : oc_count_reg + 1'b1;
		else if (quiet_clear)
			oc_count_reg <= '0;
	end

	// --------------------------------------------------------------
	// sequencer
	// --------------------------------------------------------------
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			ST_OFF:
				if (!shutdown)
					state_next = ST_START;
			ST_START:
				if (shutdown)
					state_next = ST_OFF;
				else if (trip)
					state_next = ST_HIC_DRAIN;
				else if (timer_reg >= TIMER_W'(MIN_START_CYC - 1) && pins_s[I_SSDONE])
					state_next = ST_RUN;
			ST_RUN:
				if (shutdown)
					state_next = ST_OFF;
				else if (trip)
					state_next = ST_HIC_DRAIN;
			ST_HIC_DRAIN:
				if (shutdown)
					state_next = ST_OFF;
				else if (pins_s[I_IZERO])
					state_next = ST_HIC_WAIT;
			ST_HIC_WAIT:
				if (shutdown)
					state_next = ST_OFF;
				else if (timer_reg >= TIMER_W'(HICCUP_CYC - 1))
					state_next = ST_START;
			default:
				state_next = ST_OFF;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			state_reg <= ST_OFF;
		else
			state_reg <= state_next;
	end

	// one timer serves both the hiccup wait and the shortest ramp
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			timer_reg <= '0;
		else if (state_next != state_reg)
			timer_reg <= '0;
		else if (timer_reg != {TIMER_W{1'b1}})
			timer_reg <= timer_reg + 1'b1;
	end

	// --------------------------------------------------------------
	// gate drive and soft-start
	// --------------------------------------------------------------
	// pre-biased output: no switching until soft-start passes feedback
	assign switching = (state_next == ST_RUN) || (state_next == ST_START && pins_s[I_SSFB]);

	// latch ends with the low-side on time or with the over-voltage
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			neg_block_reg <= 1'b0;
		else if (ov_s && pins_s[I_PWML] && pins_s[I_SWPOS])
			neg_block_reg <= 1'b1;
		else if (!ov_s || !pins_s[I_PWML])
			neg_block_reg <= 1'b0;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hs_en <= 1'b0;
		else
			hs_en <= switching & pins_s[I_PWMH] & ~oc_s & ~hs_block_reg & ~ot_s;
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ls_en <= 1'b0;
		else if (ot_s)
			ls_en <= 1'b0;
		else if (state_next == ST_HIC_DRAIN)
			ls_en <= ~pins_s[I_IZERO];
		else
			ls_en <= switching & pins_s[I_PWML] & ~neg_block_reg
				& ~(ov_s & pins_s[I_SWPOS]);
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ss_pulldown <= 1'b1;
		else
			ss_pulldown <= (state_next == ST_OFF) || (state_next == ST_HIC_DRAIN)
				|| (state_next == ST_HIC_WAIT);
	end

	// --------------------------------------------------------------
	// regulation flag
	// --------------------------------------------------------------
	assign pg_raw = (state_reg == ST_RUN) & ~hs_block_reg & (oc_count_reg == 3'h0) & ~oc_s
		& ~lock_s & ~ov_s & ~pins_s[I_UV] & ~pins_s[I_UNREG] & ~ot_s;

	deglitch #(
		.CYCLES(DEGLITCH_CYCLES)
	) u_pg (
		.hclk(hclk),
		.hresetn(hresetn),
		.raw(pg_raw),
		.force_low(ot_s),
		.filt(regulation_ok_flag)
	);

	// --------------------------------------------------------------
	// register slave
	// --------------------------------------------------------------
	function automatic logic reg_hit(input logic [31:0] addr, input logic [7:0] off);
		reg_hit = (addr[31:ADDR_W] == '0) && (addr[ADDR_W-1:0] == off);
	endfunction

	assign addr_valid = hsel & hready & ((htrans & HTRANS_NONSEQ_BIT1) != 2'h0);
	assign hic_clear = wr_pend_reg & reg_hit(wr_addr_reg, HICCUP_CNT_OFF);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_reg <= 1'b0;
			wr_addr_reg <= '0;
		end
		else
		begin
			wr_pend_reg <= addr_valid & hwrite;
			if (addr_valid)
				wr_addr_reg <= haddr;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_reg <= CTRL_RESET;
		else if (wr_pend_reg && reg_hit(wr_addr_reg, CTRL_OFF))
			ctrl_reg <= hwdata & CTRL_RESET;
	end

	// a trip in the clearing cycle survives the clear
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hiccup_cnt_reg <= '0;
		else if (trip)
			hiccup_cnt_reg <= hic_clear ? 8'h01 : hiccup_cnt_reg + 1'b1;
		else if (hic_clear)
			hiccup_cnt_reg <= '0;
	end

	// read data is sampled in the address phase, so a write still in its
	// data phase is forwarded
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			hrdata <= '0;
		else if (addr_valid && !hwrite)
		begin
			if (reg_hit(haddr, CTRL_OFF))
				hrdata <= (wr_pend_reg && reg_hit(wr_addr_reg, CTRL_OFF))
					? (hwdata & CTRL_RESET) : ctrl_reg;
			else if (reg_hit(haddr, STATUS_OFF))
			begin
				hrdata <= '0;
				hrdata[ST_STATE_LSB +: 3] <= state_reg;
				hrdata[ST_COUNT_LSB +: 3] <= oc_count_reg;
				hrdata[ST_OT_BIT] <= ot_s;
				hrdata[ST_OV_BIT] <= ov_s;
				hrdata[ST_UV_BIT] <= pins_s[I_UV];
				hrdata[ST_LOCKOUT_BIT] <= lock_s;
				hrdata[ST_REGULATION_OK_FLAG_BIT] <= regulation_ok_flag;
				hrdata[ST_HSBLOCK_BIT] <= hs_block_reg;
				hrdata[ST_NEGBLOCK_BIT] <= neg_block_reg;
			end
			else if (reg_hit(haddr, HICCUP_CNT_OFF))
				hrdata <= {24'h00_0000, (hic_clear && !trip) ? 8'h00 : hiccup_cnt_reg};
			else
				hrdata <= '0;
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
		else
		begin
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end
endmodule

//--- sim/fault_checker.sv
/*
 * Concurrent checks on the fault logic ports, bound into the top module.
 * Assumes pins reach outputs after two sync flops and one output flop.
 */
`timescale 1ns/1ps
module fault_checker
	import fault_pkg::*;
#(
	parameter int MIN_START_CYC = 50 // shortest ramp
) (
	input wire logic hclk, // clock
	input wire logic hresetn, // async reset, active low
	input wire logic oc_comp, // over-current
	input wire logic ov_comp, // over-voltage
	input wire logic uv_comp, // under-voltage
	input wire logic supply_lockout, // lockout
	input wire logic ot_comp, // over-temperature
	input wire logic switch_node_pos, // switch node positive
	input wire logic enable_pin, // enable
	input wire logic out_unreg, // unregulated
	input wire logic pwm_ls, // low-side request
	input wire logic hs_en, // high-side gate
	input wire logic ls_en, // low-side gate
	input wire logic ss_pulldown, // soft-start discharge
	input wire logic regulation_ok_flag // power good
);
	default clocking dc @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	logic [11:0] quiet_reg;
	logic [31:0] ramp_reg;
	// ------------------------------------------------------------
	// helper counters
	// ------------------------------------------------------------
	// saturating, so a long quiet run cannot wrap back under the limit
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			quiet_reg <= '0;
		else if (oc_comp | ov_comp | uv_comp | supply_lockout | ot_comp | out_unreg | !enable_pin)
			quiet_reg <= '0;
		else if (quiet_reg != 12'hFFF)
			quiet_reg <= quiet_reg + 12'h001;
	end
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ramp_reg <= '0;
		else if (ss_pulldown)
			ramp_reg <= '0;
		else if (ramp_reg != 32'hFFFF_FFFF)
			ramp_reg <= ramp_reg + 32'h0000_0001;
	end
	// ------------------------------------------------------------
	// assertions
	// ------------------------------------------------------------
	chk_oc_cuts_hs: assert property (oc_comp [*4] |-> !hs_en)
		else $error("high side on during over-current");
	chk_ot_gates_off: assert property (ot_comp [*4] |-> !hs_en && !ls_en)
		else $error("gate on during thermal fault");
	chk_ot_flag_low: assert property (ot_comp [*4] |-> !regulation_ok_flag)
		else $error("regulation flag high during thermal fault");
	chk_ot_discharge: assert property (ot_comp [*4] |-> ss_pulldown)
		else $error("soft-start not discharged in thermal fault");
	chk_lockout_off: assert property (supply_lockout [*4] |-> !hs_en && !ls_en && ss_pulldown)
		else $error("switching during supply lockout");
	chk_neg_limit_cut: assert property ((ov_comp && pwm_ls && switch_node_pos) [*4] |-> !ls_en)
		else $error("low side kept on with positive switch node");
	chk_pg_deglitch: assert property ($rose(regulation_ok_flag) |-> int'(quiet_reg) >= DEGLITCH_CYCLES)
		else $error("regulation flag rose before deglitch time");
	chk_start_ramp: assert property ($rose(regulation_ok_flag) |-> int'(ramp_reg) >= MIN_START_CYC)
		else $error("startup ramp shorter than minimum");
	cov_oc_cut: cover property (oc_comp [*4] ##1 !hs_en);
	cov_pg_rise: cover property ($rose(regulation_ok_flag));
	cov_drain_end: cover property ($fell(ls_en) && ss_pulldown);
endmodule

bind buck_fault_protection_logic fault_checker #(
	.MIN_START_CYC(MIN_START_CYC)
) fault_checker_inst (
	.hclk(hclk), .hresetn(hresetn), .oc_comp(oc_comp), .ov_comp(ov_comp),
	.uv_comp(uv_comp), .supply_lockout(supply_lockout), .ot_comp(ot_comp),
	.switch_node_pos(switch_node_pos), .enable_pin(enable_pin), .out_unreg(out_unreg),
	.pwm_ls(pwm_ls), .hs_en(hs_en), .ls_en(ls_en), .ss_pulldown(ss_pulldown),
	.regulation_ok_flag(regulation_ok_flag)
);

//--- sim/output_stage_model.sv
/*
 * Behavioural power stage: inductor current as a small counter.
 * Assumes gate enables from the fault logic; slow stretches the decay.
 */
`timescale 1ns/1ps
module output_stage_model (
	input wire logic hclk, // clock
	input wire logic hs_en, // high-side gate
	input wire logic ls_en, // low-side gate
	input wire logic slow, // slow current decay
	input wire logic neg_cur, // inductor current forced negative
	output logic izero_comp, // inductor current at zero
	output logic switch_node_pos // switch node above +100mV
);
	logic [3:0] cur_reg = 4'h3;
	logic [1:0] div_reg = 2'h0;
	always_ff @(posedge hclk)
	begin
		div_reg <= div_reg + 2'h1;
		if (hs_en && cur_reg != 4'hF)
			cur_reg <= cur_reg + 4'h1;
		else if (ls_en && cur_reg != 4'h0 && (!slow || div_reg == 2'h0))
			cur_reg <= cur_reg - 4'h1;
	end
	assign izero_comp = (cur_reg == 4'h0);
	// negative current lifts the node through either low-side path
	assign switch_node_pos = neg_cur && !hs_en;
endmodule

//--- sim/buck_fault_protection_logic_tb.sv
/*
 * Self-checking bench for the fault logic, one task per scenario.
 * Assumes the power stage model and the bound checker alongside.
 */
`timescale 1ns/1ps
module buck_fault_protection_logic_tb;
	import fault_pkg::*;
	localparam int HIC = 50;
	localparam int MSTART = 50;
	localparam logic [31:0] A_CTRL = {24'h00_0000, CTRL_OFF};
	localparam logic [31:0] A_ST = {24'h00_0000, STATUS_OFF};
	localparam logic [31:0] A_HIC = {24'h00_0000, HICCUP_CNT_OFF};
	logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, oc_comp, ov_comp, uv_comp;
	logic supply_lockout, ot_comp, switch_node_pos, izero_comp, sw_cycle, enable_pin;
	logic out_unreg, ss_above_fb, pwm_hs, pwm_ls, ss_done, hs_en, ls_en, ss_pulldown;
	logic regulation_ok_flag, slow, neg_cur;
	logic [31:0] haddr, hwdata, hrdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [4:0] sw_cnt = 5'h00;
	int n_fail, n_checks;
	buck_fault_protection_logic #(
		.HICCUP_CYC(HIC),
		.MIN_START_CYC(MSTART)
	) buck_fault_protection_logic_inst (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .oc_comp(oc_comp),
		.ov_comp(ov_comp), .uv_comp(uv_comp), .supply_lockout(supply_lockout),
		.ot_comp(ot_comp), .switch_node_pos(switch_node_pos), .izero_comp(izero_comp),
		.sw_cycle(sw_cycle), .enable_pin(enable_pin), .out_unreg(out_unreg),
		.ss_above_fb(ss_above_fb), .pwm_hs(pwm_hs), .pwm_ls(pwm_ls), .ss_done(ss_done),
		.hs_en(hs_en), .ls_en(ls_en), .ss_pulldown(ss_pulldown),
		.regulation_ok_flag(regulation_ok_flag)
	);
	output_stage_model output_stage_model_inst (
		.hclk(hclk), .hs_en(hs_en), .ls_en(ls_en), .slow(slow), .neg_cur(neg_cur),
		.izero_comp(izero_comp), .switch_node_pos(switch_node_pos)
	);
	// ------------------------------------------------------------
	// clock and modulator, 20 clocks per switching cycle
	// ------------------------------------------------------------
	initial
	begin
		hclk = 1'b0;
		forever #5 hclk = ~hclk;
	end
	always @(posedge hclk)
	begin
		sw_cnt <= (sw_cnt == 5'h13) ? 5'h00 : sw_cnt + 5'h01;
		sw_cycle <= (sw_cnt < 5'h0A);
		pwm_hs <= (sw_cnt < 5'h08);
		pwm_ls <= (sw_cnt >= 5'h0A);
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task automatic check(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1)
		begin
			n_fail++;
			$display("mismatch at %0t: %s", $time, msg);
		end
	endtask
	task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
		output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= HTRANS_NONSEQ_BIT1;
		haddr <= a;
		hwrite <= wr;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge hclk);
		while (hreadyout !== 1'b1)
			@(posedge hclk);
		rd = hrdata;
		check(hresp === 1'b0, "error response");
	endtask
	task automatic at_cnt(input logic [4:0] c);
		do
		begin
			@(posedge hclk);
			#1;
		end
		while (sw_cnt != c);
	endtask
	// oc held five clocks, well inside one switching cycle
	task automatic oc_pulse(input logic [4:0] c);
		at_cnt(c);
		@(posedge hclk);
		oc_comp <= 1'b1;
		repeat (5) @(posedge hclk);
		oc_comp <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_startup;
		int n;
		logic [31:0] d;
		n = 0;
		while (regulation_ok_flag !== 1'b1 && n < 4000)
		begin
			@(posedge hclk);
			n++;
		end
		check(regulation_ok_flag === 1'b1, "no regulation flag after start");
		check(n >= MSTART + DEGLITCH_CYCLES, "startup too fast");
		bus(1'b0, A_ST, '0, d);
		check(d[2:0] === ST_RUN && ss_pulldown === 1'b0, "not running");
	endtask
	task automatic t_regs;
		logic [31:0] d;
		bus(1'b0, A_CTRL, '0, d);
		check(d === CTRL_RESET, "control reset value");
		bus(1'b1, 32'h0000_0040, 32'hFFFF_FFFF, d);
		bus(1'b0, 32'h0000_0040, '0, d);
		check(d === 32'h0000_0000, "unmapped read not zero");
	endtask
	task automatic t_pg;
		@(posedge hclk);
		out_unreg <= 1'b1;
		repeat (1500) @(posedge hclk);
		#1 check(regulation_ok_flag === 1'b1, "flag fell too early");
		repeat (600) @(posedge hclk);
		#1 check(regulation_ok_flag === 1'b0, "flag high while unregulated");
		@(posedge hclk);
		out_unreg <= 1'b0;
		repeat (2100) @(posedge hclk);
		#1 check(regulation_ok_flag === 1'b1, "flag did not return");
	endtask
	task automatic t_neg;
		@(posedge hclk);
		neg_cur <= 1'b1;
		at_cnt(5'h11);
		check(ls_en === 1'b1, "negative limit active without over-voltage");
		@(posedge hclk);
		ov_comp <= 1'b1;
		repeat (40) @(posedge hclk);
		at_cnt(5'h11);
		check(ls_en === 1'b0, "low side not cut");
		@(posedge hclk);
		ov_comp <= 1'b0;
		neg_cur <= 1'b0;
	endtask
	task automatic t_faults;
		logic [31:0] d;
		for (int k = 0; k < 4; k++)
		begin
			repeat (100) @(posedge hclk);
			case (k)
				0: ot_comp <= 1'b1;
				1: supply_lockout <= 1'b1;
				2: enable_pin <= 1'b0;
				default: bus(1'b1, A_CTRL, 32'h0000_0000, d);
			endcase
			repeat (5) @(posedge hclk);
			#1 check(!hs_en && !ls_en && ss_pulldown === 1'b1, "fault left switching");
			check(k != 0 || regulation_ok_flag === 1'b0, "flag high when hot");
			@(posedge hclk);
			ot_comp <= 1'b0;
			supply_lockout <= 1'b0;
			enable_pin <= 1'b1;
			if (k == 3)
				bus(1'b1, A_CTRL, CTRL_RESET, d);
		end
		repeat (200) @(posedge hclk);
	endtask
	task automatic t_oc;
		logic [31:0] d;
		oc_pulse(5'h02);
		at_cnt(5'h09);
		check(hs_en === 1'b0, "high side not cut");
		oc_pulse(5'h0C);
		at_cnt(5'h09);
		check(hs_en === 1'b1, "high side still blocked");
		bus(1'b0, A_ST, '0, d);
		check(d[6:4] === 3'h1, "one event per cycle");
		repeat (600) @(posedge hclk);
		bus(1'b0, A_ST, '0, d);
		check(d[6:4] === 3'h1, "count cleared early");
		repeat (60) @(posedge hclk);
		bus(1'b0, A_ST, '0, d);
		check(d[6:4] === 3'h0, "count not cleared");
		for (int i = 0; i < 4; i++)
		begin
			oc_pulse(5'h02);
			repeat (460) @(posedge hclk);
		end
		bus(1'b0, A_ST, '0, d);
		check(d[6:4] === 3'h4 && d[2:0] === ST_RUN, "four events");
	endtask
	task automatic t_hiccup;
		int n;
		logic [31:0] d;
		slow <= 1'b1;
		oc_pulse(5'h02);
		@(posedge hclk);
		#1 check(!hs_en && ls_en === 1'b1 && ss_pulldown === 1'b1, "hiccup entry");
		n = 0;
		while (ls_en === 1'b1 && n < 500)
		begin
			@(posedge hclk);
			#1 n++;
		end
		check(!hs_en && !ls_en && izero_comp === 1'b1, "drain end");
		n = 0;
		while (ss_pulldown === 1'b1 && n < 500)
		begin
			@(posedge hclk);
			#1 n++;
		end
		check(n >= HIC - 2 && n <= HIC + 3, "hiccup wait length");
		bus(1'b0, A_ST, '0, d);
		check(d[2:0] === ST_START && d[6:4] === 3'h0, "restart");
		bus(1'b0, A_HIC, '0, d);
		check(d[7:0] === 8'h01, "hiccup count");
		slow <= 1'b0;
	endtask
	// ------------------------------------------------------------
	// sequence, watchdog and verdict
	// ------------------------------------------------------------
	task automatic results;
		$display("checks %0d, mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	initial
	begin
		#400_000;
		n_fail++;
		$display("mismatch at %0t: watchdog expired", $time);
		results;
	end
	initial
	begin
		{hresetn, hsel, hwrite, oc_comp, ov_comp, uv_comp, supply_lockout} = '0;
		{ot_comp, out_unreg, slow, neg_cur} = '0;
		{enable_pin, ss_above_fb, ss_done} = 3'h7;
		haddr = '0;
		hwdata = '0;
		htrans = 2'h0;
		hsize = 3'h2;
		n_fail = 0;
		n_checks = 0;
		repeat (3) @(posedge hclk);
		hresetn <= 1'b1;
		t_startup;
		t_regs;
		t_pg;
		t_neg;
		t_faults;
		t_oc;
		t_hiccup;
		results;
	end
endmodule
